// file: rtl/rx_gain_freq_tracking.sv
// Gain control, corrected signal level readout and frequency tracking
// loop of a sub-GHz receiver baseband, with its register file.
// Assumes the host interface decodes serial frames into reg_req and
// that demodulator settings come from registers outside this block.
//
// Functional notes
// - Switch to low gain when raw level exceeds the attack threshold.
// - Switch back to high gain when raw level falls below release threshold.
// - Mode field 0 disables gain control, 1 to 3 enable, reset 2.
// - Gain-corrected level readable at 0x10, half dB per step.
// - Peak detector discharges one step per 1.67us times 2 to N.
// - Tracking offset limited to limit field times 16.
// - Limit field zero holds the centre frequency, no tracking.
// - Tracking offset readable at 0x11 as 8-bit two's complement.
// - Reported error magnitude can exceed 16 times a lowered limit field until the next receive update.
// - Tracking restarts whenever receiver enters continuous or polled receive from inactive or other state.
// - FSK continuous receive with hold bit set freezes offset after preamble.
// - Preamble freeze unavailable in ASK mode.
// - Modulation choice 0 selects ASK, 1 selects FSK.
// - IF choice 0 selects 400 kHz, 1 selects 200 kHz.
`timescale 1ns/100ps
`default_nettype none
`include "rx_track_defs.svh"

module rx_gain_freq_tracking
  import rx_track_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `DISCHARGE_STEP_CYCLES,
  parameter logic [7:0] ATTACK_LEVEL = `ATTACK_LEVEL_DEF,
  parameter logic [7:0] GAIN_STEP = `GAIN_STEP_DEF
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire reg_req_t reg_req, // Decoded register access
  output logic [7:0] reg_rdata, // Read data, registered
  input wire rx_cfg_t rx_cfg, // Filter and demodulator settings
  input wire rx_state_t rx_state, // Receiver operating state
  input wire logic [7:0] raw_level, // Raw envelope level
  input wire logic freq_err_valid, // Frequency detector sample strobe
  input wire logic signed [7:0] freq_err_sample, // Detector error sample
  input wire logic preamble_found, // Preamble detector pulse
  output logic high_gain, // Front end in high gain
  output logic fsk_demod_choice, // FSK demodulator selected
  output logic if_200k, // 200 kHz IF selected
  output logic signed [7:0] synth_offset, // Offset applied to synthesizer
  output logic tracking_frozen // Offset held after preamble
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Largest offset magnitude allowed by the limit field
  function automatic logic signed [9:0] offset_bound(input logic [2:0] lim);
    offset_bound = 10'(lim) * 10'(`LIMIT_SCALE);
  endfunction : offset_bound

  function automatic logic signed [9:0] clamp(input logic signed [9:0] v,
                                              input logic [2:0] lim);
    logic signed [9:0] b;
    b = offset_bound(lim);
    if (v > b) begin
      clamp = b;
    end else if (v < -b) begin
      clamp = -b;
    end else begin
      clamp = v;
    end
  endfunction : clamp

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_GAIN_CFG,
    SEL_TRACK_CFG1,
    SEL_TRACK_CFG2,
    SEL_LEVEL,
    SEL_FREQ_ERR
  } reg_sel_t;

  // One decode serves writes and reads so the two paths cannot disagree
  function automatic reg_sel_t reg_select(input logic [7:0] addr);
    case (addr)
      `OFS_GAIN_CONTROL_CFG: reg_select = SEL_GAIN_CFG;
      `OFS_FREQ_TRACK_CFG1: reg_select = SEL_TRACK_CFG1;
      `OFS_FREQ_TRACK_CFG2: reg_select = SEL_TRACK_CFG2;
      `OFS_SIGNAL_LEVEL_READOUT: reg_select = SEL_LEVEL;
      `OFS_FREQ_ERROR_READOUT: reg_select = SEL_FREQ_ERR;
      default: reg_select = SEL_NONE;
    endcase
  endfunction : reg_select

  ////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] gain_control_cfg_q;
  logic [7:0] freq_track_cfg1_q;
  logic [7:0] freq_track_cfg2_q;
  logic [7:0] signal_level_readout_q;
  logic [7:0] freq_error_readout_q;

  logic [1:0] gain_control_mode;
  logic [1:0] level_discharge_setting;
  logic [3:0] gain_release_threshold;
  logic [2:0] tracking_offset_limit;
  logic [1:0] tracking_loop_gain;
  logic hold_tracking_on_preamble;
  reg_sel_t reg_sel;

  assign gain_control_mode = gain_control_cfg_q[`GAIN_MODE_LSB +: 2];
  assign level_discharge_setting = gain_control_cfg_q[`GAIN_DISCHARGE_LSB +: 2];
  assign gain_release_threshold = gain_control_cfg_q[`GAIN_RELEASE_LSB +: 4];
  assign tracking_offset_limit = freq_track_cfg1_q[`TRACK_LIMIT_LSB +: 3];
  assign tracking_loop_gain = freq_track_cfg1_q[`TRACK_GAIN_LSB +: 2];
  assign hold_tracking_on_preamble = freq_track_cfg2_q[`HOLD_PREAMBLE_BIT];
  assign reg_sel = reg_select(reg_req.addr);

  always_ff @(posedge clk) begin
    if (rst) begin
      gain_control_cfg_q <= `GAIN_CONTROL_CFG_RST;
      freq_track_cfg1_q <= `FREQ_TRACK_CFG1_RST;
      freq_track_cfg2_q <= `FREQ_TRACK_CFG2_RST;
    end else if (reg_req.wr) begin
      case (reg_sel)
        SEL_GAIN_CFG: gain_control_cfg_q <= reg_req.wdata;
        SEL_TRACK_CFG1: freq_track_cfg1_q <= {3'h0, reg_req.wdata[4:0]};
        SEL_TRACK_CFG2: freq_track_cfg2_q <= {7'h00, reg_req.wdata[0]};
        default: ;
      endcase
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_sel)
        SEL_GAIN_CFG: reg_rdata <= gain_control_cfg_q;
        SEL_TRACK_CFG1: reg_rdata <= freq_track_cfg1_q;
        SEL_TRACK_CFG2: reg_rdata <= freq_track_cfg2_q;
        SEL_LEVEL: reg_rdata <= signal_level_readout_q;
        SEL_FREQ_ERR: reg_rdata <= freq_error_readout_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode decode

  logic rx_active;
  logic rx_active_q;
  logic rx_start;

  assign fsk_demod_choice = rx_cfg.modulation_choice;
  assign if_200k = rx_cfg.if_choice;
  assign rx_active = (rx_state == RX_CONTINUOUS) || (rx_state == RX_POLLED);
  assign rx_start = rx_active && !rx_active_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_active_q <= 1'b0;
    end else begin
      rx_active_q <= rx_active;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Gain control with hysteresis

  logic [7:0] release_level;
  logic high_gain_q;
  logic high_gain_d;

  // Release threshold scales into the upper nibble of the raw level;
  // software must keep it below the attack level or the gain chatters.
  assign release_level = {gain_release_threshold, 4'h0};

  always_comb begin
    high_gain_d = high_gain_q;
    if (gain_control_mode == `GAIN_MODE_OFF) begin
      high_gain_d = 1'b1;
    end else if (high_gain_q && raw_level > ATTACK_LEVEL) begin
      high_gain_d = 1'b0;
    end else if (!high_gain_q && raw_level < release_level) begin
      high_gain_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      high_gain_q <= 1'b1;
    end else begin
      high_gain_q <= high_gain_d;
    end
  end

  assign high_gain = high_gain_q;

  ////////////////////////////////////////////////////////////////////
  // Corrected signal level

  logic [7:0] peak_level;
  logic [5:0] exp_sum;
  logic [4:0] step_exp;
  logic [8:0] corrected;

  assign exp_sum = 6'(rx_cfg.if_choice) + 6'(rx_cfg.channel_filter_choice)
                 + 6'(rx_cfg.demod_time_control) + 6'(level_discharge_setting);
  assign step_exp = (exp_sum == 6'h00) ? 5'h00 : 5'(exp_sum - 6'h01);

  level_peak_detector #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_peak (
    .clk(clk),
    .rst(rst),
    .level_in(raw_level),
    .step_exp(step_exp),
    .peak(peak_level)
  );

  // Low gain hides GAIN_STEP half-dB units; add them back, saturating
  assign corrected = {1'b0, peak_level} + (high_gain ? 9'h000 : {1'b0, GAIN_STEP});

  always_ff @(posedge clk) begin
    if (rst) begin
      signal_level_readout_q <= 8'h00;
    end else if (rx_active) begin
      signal_level_readout_q <= corrected[8] ? 8'hff : corrected[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frequency tracking loop

  logic signed [9:0] step;
  logic signed [9:0] next_offset;
  logic signed [9:0] held_offset;
  logic signed [7:0] synth_offset_q;
  logic signed [7:0] synth_offset_d;
  logic tracking_frozen_q;
  logic tracking_frozen_d;
  logic freeze_event;

  // Higher loop gain takes larger steps and settles faster
  assign step = 10'(freq_err_sample) >>> (2'd3 - tracking_loop_gain);
  assign next_offset = clamp(10'(synth_offset_q) + step, tracking_offset_limit);
  // A lowered limit pulls a held offset back inside the new bound
  assign held_offset = clamp(10'(synth_offset_q), tracking_offset_limit);
  assign freeze_event = preamble_found && fsk_demod_choice && rx_state == RX_CONTINUOUS
                        && hold_tracking_on_preamble;

  // A preamble on the first active cycle still freezes: the set wins
  always_comb begin
    tracking_frozen_d = tracking_frozen_q;
    if (!rx_active) begin
      tracking_frozen_d = 1'b0;
    end else if (freeze_event) begin
      tracking_frozen_d = 1'b1;
    end else if (rx_start) begin
      tracking_frozen_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tracking_frozen_q <= 1'b0;
    end else begin
      tracking_frozen_q <= tracking_frozen_d;
    end
  end

  always_comb begin
    synth_offset_d = held_offset[7:0];
    if (rx_start || tracking_offset_limit == 3'h0) begin
      synth_offset_d = 8'sh00;
    end else if (rx_active && !tracking_frozen_q && freq_err_valid) begin
      synth_offset_d = next_offset[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      synth_offset_q <= 8'sh00;
    end else begin
      synth_offset_q <= synth_offset_d;
    end
  end

  assign synth_offset = synth_offset_q;
  assign tracking_frozen = tracking_frozen_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      freq_error_readout_q <= 8'h00;
    end else if (rx_active) begin
      freq_error_readout_q <= synth_offset;
    end
  end

endmodule : rx_gain_freq_tracking

`default_nettype wire

// file: rtl/rx_track_defs.svh
// Register offsets, field positions, reset values and timing counts
// for the receiver gain and frequency tracking block.
// Assumes a 100 MHz clock; included by bare name.
`ifndef RX_TRACK_DEFS_SVH
`define RX_TRACK_DEFS_SVH

`define CLK_PERIOD_NS 10
`define DISCHARGE_STEP_NS 1670
`define DISCHARGE_STEP_CYCLES ((`DISCHARGE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define OFS_GAIN_CONTROL_CFG 8'h01
`define OFS_FREQ_TRACK_CFG1 8'h07
`define OFS_FREQ_TRACK_CFG2 8'h08
`define OFS_SIGNAL_LEVEL_READOUT 8'h10
`define OFS_FREQ_ERROR_READOUT 8'h11

`define GAIN_MODE_LSB 0
`define GAIN_DISCHARGE_LSB 2
`define GAIN_RELEASE_LSB 4
`define TRACK_LIMIT_LSB 0
`define TRACK_GAIN_LSB 3
`define HOLD_PREAMBLE_BIT 0

`define GAIN_CONTROL_CFG_RST 8'h92
`define FREQ_TRACK_CFG1_RST 8'h10
`define FREQ_TRACK_CFG2_RST 8'h00

`define GAIN_MODE_OFF 2'h0
`define ATTACK_LEVEL_DEF 8'hc0
`define GAIN_STEP_DEF 8'h50
`define LIMIT_SCALE 16

`endif

// file: rtl/rx_track_pkg.sv
// Types shared by the gain and frequency tracking block.
// Constants live in rx_track_defs.svh.
package rx_track_pkg;

  typedef enum logic [1:0] {
    RX_INACTIVE,
    RX_CONTINUOUS,
    RX_POLLED,
    RX_OTHER
  } rx_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic if_choice;
    logic [2:0] channel_filter_choice;
    logic [2:0] demod_time_control;
    logic modulation_choice;
  } rx_cfg_t;

endpackage : rx_track_pkg

// file: rtl/level_peak_detector.sv
// Peak detector on the raw signal level with stepped discharge.
// Assumes the step exponent is stable while the receiver runs.
`timescale 1ns/100ps
`default_nettype none

module level_peak_detector #(
  parameter int unsigned STEP_CYCLES = 167
) (
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic [7:0] level_in, // Raw envelope level
  input wire logic [4:0] step_exp, // Discharge exponent N
  output logic [7:0] peak // Held peak
);

  logic [7:0] peak_q;
  logic [39:0] tick_q;
  logic [39:0] period;

  // Period of one 0.5 dB step is STEP_CYCLES * 2^N
  assign period = 40'(STEP_CYCLES) << step_exp;
  assign peak = peak_q;

  always_ff @(posedge clk) begin
    if (rst || level_in >= peak_q || tick_q + 40'h1 >= period) begin
      tick_q <= 40'h0;
    end else begin
      tick_q <= tick_q + 40'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      peak_q <= 8'h00;
    end else if (level_in >= peak_q) begin
      peak_q <= level_in;
    end else if (tick_q + 40'h1 >= period && peak_q != 8'h00) begin
      peak_q <= peak_q - 8'h01;
    end
  end

endmodule : level_peak_detector

`default_nettype wire

// file: tb/rx_track_asserts.sv
// Checker for the gain and tracking block, bound to every instance.
// Mirrors the gain configuration, limit field and hold bit from register writes seen at the port.
`timescale 1ns/100ps
`default_nettype none
`include "rx_track_defs.svh"
module rx_track_asserts
  import rx_track_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire reg_req_t reg_req, // Register access
  input wire rx_cfg_t rx_cfg, // Receiver settings
  input wire rx_state_t rx_state, // Receiver state
  input wire logic [7:0] raw_level, // Raw level
  input wire logic preamble_found, // Preamble pulse
  input wire logic high_gain, // Gain state
  input wire logic fsk_demod_choice, // FSK selected
  input wire logic if_200k, // 200 kHz IF
  input wire logic signed [7:0] synth_offset, // Offset
  input wire logic tracking_frozen // Offset held
);
  logic [7:0] agc_q;
  logic [2:0] lim_q;
  logic hold_q;
  logic [8:0] mag;

  // Nine bits so that -128 keeps its magnitude
  assign mag = synth_offset[7] ? 9'h000 - {1'b1, synth_offset} : {1'b0, synth_offset};

  always_ff @(posedge clk) begin
    if (rst) begin
      agc_q <= `GAIN_CONTROL_CFG_RST;
      lim_q <= 3'h0;
      hold_q <= 1'b0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == 8'h01) agc_q <= reg_req.wdata;
      if (reg_req.addr == 8'h07) lim_q <= reg_req.wdata[2:0];
      if (reg_req.addr == 8'h08) hold_q <= reg_req.wdata[0];
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_attack_low_gain: assert property (
    agc_q[1:0] != 2'h0 && high_gain && raw_level > `ATTACK_LEVEL_DEF |=> !high_gain)
    else $error("no attack above threshold");
  a_release_high: assert property (
    agc_q[1:0] != 2'h0 && !high_gain && raw_level < {agc_q[7:4], 4'h0} |=> high_gain)
    else $error("no release below threshold");
  a_mode_off_high: assert property (agc_q[1:0] == 2'h0 |=> high_gain)
    else $error("low gain while gain control off");
  a_fsk_select: assert property (fsk_demod_choice == rx_cfg.modulation_choice)
    else $error("demodulator choice wrong");
  a_if_select: assert property (if_200k == rx_cfg.if_choice)
    else $error("intermediate frequency choice wrong");
  a_limit_zero_hold: assert property (lim_q == 3'h0 |=> synth_offset == 8'sh00)
    else $error("offset moved with zero limit");
  a_offset_in_range: assert property ($stable(lim_q) |-> mag <= {2'h0, lim_q, 4'h0})
    else $error("offset beyond limit");
  a_freeze_on_pre: assert property (preamble_found && rx_cfg.modulation_choice && hold_q
    && rx_state == RX_CONTINUOUS && $stable(rx_state) |=> tracking_frozen)
    else $error("no freeze after preamble");
  a_ask_no_freeze: assert property (
    !rx_cfg.modulation_choice && !tracking_frozen |=> !tracking_frozen)
    else $error("freeze in amplitude mode");
endmodule : rx_track_asserts

bind rx_gain_freq_tracking rx_track_asserts chk_i (.clk, .rst, .reg_req, .rx_cfg,
  .rx_state, .raw_level, .preamble_found, .high_gain, .fsk_demod_choice, .if_200k,
  .synth_offset, .tracking_frozen);
`default_nettype wire

// file: tb/host_model.sv
// Host model: one-cycle register writes and reads on the decoded port.
// Assumes read data is valid one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module host_model
  import rx_track_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic [7:0] reg_rdata, // Read data
  output var reg_req_t reg_req // Register access
);
  initial reg_req = '{8'h00, 1'b0, 1'b0, 8'h00};

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{a, 1'b1, 1'b0, d};
    @(posedge clk);
    // Stale data is inverted so nothing relies on a released bus
    reg_req <= '{a, 1'b0, 1'b0, ~d};
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd_reg
endmodule : host_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the gain and tracking block.
// Host model drives registers; the bench drives the receiver side.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rx_track_pkg::*;
  logic clk = 1'b0, rst = 1'b1, fv = 1'b0, pf = 1'b0;
  logic [7:0] raw = 8'h00, rdata, rd, fs = 8'h00;
  rx_cfg_t cfg = '0;
  rx_state_t st = RX_INACTIVE;
  reg_req_t req;
  logic hg, fsk, if2, frz;
  logic signed [7:0] ofs;
  int mismatches = 0, samples_checked = 0;

  host_model host_model_i (.clk(clk), .reg_rdata(rdata), .reg_req(req));
  rx_gain_freq_tracking #(.STEP_CYCLES(2)) rx_gain_freq_tracking_i (.clk(clk), .rst(rst),
    .reg_req(req), .reg_rdata(rdata), .rx_cfg(cfg), .rx_state(st), .raw_level(raw),
    .freq_err_valid(fv), .freq_err_sample(fs), .preamble_found(pf), .high_gain(hg),
    .fsk_demod_choice(fsk), .if_200k(if2), .synth_offset(ofs), .tracking_frozen(frz));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic pulse(input logic p, input logic v, input logic [7:0] s);
    @(posedge clk);
    pf <= p;
    fv <= v;
    fs <= s;
    @(posedge clk);
    pf <= 1'b0;
    fv <= 1'b0;
    fs <= ~s;
    #1;
  endtask : pulse

  task automatic go(input rx_state_t s, input int n);
    @(posedge clk);
    st <= s;
    repeat (n) @(posedge clk);
    #1;
  endtask : go

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_model_i.rd_reg(a, rd);
    chk(rd, exp);
  endtask : rchk

  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    host_model_i.wr_reg(8'h10, 8'h5a);
    rchk(8'h01, 8'h92);
    rchk(8'h07, 8'h10);
    rchk(8'h08, 8'h00);
    rchk(8'h10, 8'h00);
    rchk(8'h11, 8'h00);
    rchk(8'h20, 8'h00);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      host_model_i.wr_reg(8'h01, 8'h90 | 8'(m));
      @(posedge clk) raw <= 8'hd0;
      repeat (3) @(posedge clk);
      #1 chk(8'(hg), 8'(m == 0));
      @(posedge clk) raw <= 8'h80;
      repeat (3) @(posedge clk);
      #1 chk(8'(hg), 8'h01);
    end
    $display("test gain done");
    // Decay exponent 1 gives one step per four cycles
    @(posedge clk) cfg <= '{1'b0, 3'h0, 3'h2, 1'b0};
    @(posedge clk) raw <= 8'hd0;
    go(RX_CONTINUOUS, 3);
    @(posedge clk) raw <= 8'ha0;
    repeat (140) @(posedge clk);
    rchk(8'h10, 8'hfd);
    repeat (200) @(posedge clk);
    rchk(8'h10, 8'hf0);
    go(RX_INACTIVE, 2);
    @(posedge clk) raw <= 8'h40;
    repeat (20) @(posedge clk);
    rchk(8'h10, 8'hf0);
    $display("test level done");
    // Centre word is set outside; only the offset around it is seen here
    host_model_i.wr_reg(8'h07, 8'h1a);
    @(posedge clk) cfg <= '{1'b1, 3'h0, 3'h0, 1'b1};
    go(RX_CONTINUOUS, 3);
    chk(8'(fsk), 8'h01);
    chk(8'(if2), 8'h01);
    pulse(1'b0, 1'b1, 8'h10);
    chk(ofs, 8'h10);
    pulse(1'b0, 1'b1, 8'h30);
    chk(ofs, 8'h20);
    rchk(8'h11, 8'h20);
    pulse(1'b0, 1'b1, 8'ha0);
    chk(ofs, 8'he0);
    host_model_i.wr_reg(8'h08, 8'h01);
    pulse(1'b1, 1'b0, 8'h00);
    chk(8'(frz), 8'h01);
    pulse(1'b0, 1'b1, 8'h10);
    chk(ofs, 8'he0);
    go(RX_INACTIVE, 2);
    go(RX_POLLED, 3);
    pulse(1'b0, 1'b1, 8'h08);
    chk(ofs, 8'h08);
    @(posedge clk) cfg <= '0;
    go(RX_CONTINUOUS, 2);
    chk(8'(fsk), 8'h00);
    chk(8'(if2), 8'h00);
    pulse(1'b1, 1'b0, 8'h00);
    chk(8'(frz), 8'h00);
    pulse(1'b0, 1'b1, 8'h08);
    chk(ofs, 8'h10);
    host_model_i.wr_reg(8'h07, 8'h18);
    repeat (3) @(posedge clk);
    #1 chk(ofs, 8'h00);
    @(posedge clk) cfg <= '{1'b0, 3'h0, 3'h0, 1'b1};
    host_model_i.wr_reg(8'h07, 8'h12);
    pulse(1'b0, 1'b1, 8'h20);
    chk(ofs, 8'h10);
    $display("test tracking done");
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
